// *** rsx_exec.v ***
`timescale 1ns/1ps
`include "rsx_defines.vh"

// Operation
// RULE1: halt clears watchdog counter and prescaler
// RULE2: halt sets expiry bit, clears power-down bit
// RULE3: halt enters halted state, oscillator stopped
// RULE4: rotate left through carry
// RULE5: rotate right through carry
// RULE6: subtract accumulator from file, update carry, half, zero
// RULE7: nibble exchange, flags unchanged
// RULE8: accumulator to direction register 6 or 7
// RULE9: xor accumulator with file, zero only
// RULE10: xor accumulator with literal into accumulator
// RULE11: destination bit selects accumulator or file
// RULE12: zero flag set when result zero
module rsx_exec #(
  parameter WDOG_W = 8,
  parameter PRE_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`RSX_ADDR_W-1:0] paddr,
  input wire [`RSX_DATA_W-1:0] pwdata,
  output reg [`RSX_DATA_W-1:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg halted_q,
  output reg osc_run_q,
  output reg [`RSX_BYTE_W-1:0] dir_a_q,
  output reg [`RSX_BYTE_W-1:0] dir_b_q
);

  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_HALT = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`RSX_BYTE_W-1:0] acc_q;
  reg [`RSX_ST_W-1:0] status_q;
  reg [WDOG_W-1:0] wdog_q;
  reg [PRE_W-1:0] pre_q;
  reg [`RSX_BYTE_W-1:0] file_q [0:`RSX_FILE_N-1];
  reg [`RSX_DATA_W-1:0] rdata_d;
  reg [`RSX_BYTE_W-1:0] acc_d;
  reg [`RSX_ST_W-1:0] status_d;
  reg [WDOG_W-1:0] wdog_d;
  reg [PRE_W-1:0] pre_d;
  reg [`RSX_BYTE_W-1:0] dir_a_d;
  reg [`RSX_BYTE_W-1:0] dir_b_d;

  wire access;
  wire wr_strobe;
  wire rd_strobe;
  wire [`RSX_OP_W-1:0] cmd_op;
  wire [`RSX_FILE_IDX_W-1:0] cmd_f;
  wire cmd_d;
  wire [`RSX_BYTE_W-1:0] cmd_lit;
  wire [`RSX_BYTE_W-1:0] cmd_fval;
  wire [`RSX_FILE_IDX_W-1:0] bus_idx;
  wire bus_is_file;
  wire [`RSX_BYTE_W-1:0] alu_res;
  wire alu_carry;
  wire alu_half;
  wire alu_zero;
  wire alu_wr_carry;
  wire alu_wr_half;
  wire alu_wr_zero;
  wire cmd_hit;
  wire cmd_ok;
  wire exec;
  wire to_file;
  wire to_acc;
  wire wake_hit;
  wire addr_ok;
  wire halt_exec;

  // decode of operations that use a destination bit
  function uses_dest;
    input [`RSX_OP_W-1:0] op;
    begin
      case (op)
        `RSX_OP_ROT_L, `RSX_OP_ROT_R, `RSX_OP_SUB, `RSX_OP_SWAP,
        `RSX_OP_XOR_F: uses_dest = 1'b1;
        default: uses_dest = 1'b0;
      endcase
    end
  endfunction

  // decode of operation codes that are legal
  function op_legal;
    input [`RSX_OP_W-1:0] op;
    input [`RSX_FILE_IDX_W-1:0] f;
    begin
      case (op)
        `RSX_OP_SLEEP, `RSX_OP_XOR_L: op_legal = 1'b1;
        `RSX_OP_DIR: op_legal = (f == `RSX_DIR_SEL_A) || (f == `RSX_DIR_SEL_B);
        default: op_legal = uses_dest(op);
      endcase
    end
  endfunction

  // bus access phase, answered one cycle after it opens
  assign access = psel & penable & ~pready;
  assign wr_strobe = psel & penable & pready & pwrite;
  assign rd_strobe = access & ~pwrite;

  assign cmd_op = pwdata[`RSX_OP_HI:`RSX_OP_LO];
  assign cmd_f = pwdata[`RSX_F_HI:`RSX_F_LO];
  assign cmd_d = pwdata[`RSX_D_BIT];
  assign cmd_lit = pwdata[`RSX_LIT_HI:`RSX_LIT_LO];
  assign cmd_fval = file_q[cmd_f];

  assign bus_idx = paddr[`RSX_ADDR_IDX_HI:`RSX_ADDR_IDX_LO];
  assign bus_is_file = paddr[`RSX_ADDR_FILE_SEL_HI];

  assign cmd_hit = (paddr == `RSX_ADDR_CMD);
  assign wake_hit = (paddr == `RSX_ADDR_WAKE);
  assign cmd_ok = op_legal(cmd_op, cmd_f) && state_q[0];
  assign exec = wr_strobe & cmd_hit & cmd_ok;
  assign halt_exec = exec & (cmd_op == `RSX_OP_SLEEP);
  assign to_file = exec & uses_dest(cmd_op) & (cmd_d == `RSX_DEST_FILE); // RULE11
  assign to_acc = exec & ((uses_dest(cmd_op) & (cmd_d == `RSX_DEST_ACC)) |
                  (cmd_op == `RSX_OP_XOR_L)); // RULE11

  assign addr_ok = bus_is_file ||
                   (paddr == `RSX_ADDR_CMD) || (paddr == `RSX_ADDR_ACC) ||
                   (paddr == `RSX_ADDR_STATUS) || (paddr == `RSX_ADDR_WDOG) ||
                   (paddr == `RSX_ADDR_DIR) || (paddr == `RSX_ADDR_WAKE);

  rsx_alu u_alu (
    .op(cmd_op),
    .acc(acc_q),
    .fval(cmd_fval),
    .lit(cmd_lit),
    .carry_in(status_q[`RSX_ST_CARRY]),
    .res(alu_res),
    .carry_out(alu_carry),
    .half_out(alu_half),
    .zero_out(alu_zero),
    .wr_carry(alu_wr_carry),
    .wr_half(alu_wr_half),
    .wr_zero(alu_wr_zero)
  );

  // bus handshake and error answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      if (access) begin
        if (!addr_ok) begin
          pslverr <= 1'b1;
        end else if (pwrite && cmd_hit) begin
          pslverr <= ~cmd_ok;
        end else begin
          pslverr <= 1'b0;
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // read data selection, upper bits read zero
  always @* begin
    rdata_d = {`RSX_DATA_W{1'b0}};
    if (bus_is_file) begin
      rdata_d[`RSX_BYTE_W-1:0] = file_q[bus_idx];
    end else begin
      case (paddr)
        `RSX_ADDR_ACC: rdata_d[`RSX_BYTE_W-1:0] = acc_q;
        `RSX_ADDR_STATUS: rdata_d[`RSX_ST_W-1:0] = status_q;
        `RSX_ADDR_WDOG: begin
          rdata_d[`RSX_WD_CNT_HI:`RSX_WD_CNT_LO] = wdog_q[`RSX_BYTE_W-1:0];
          rdata_d[`RSX_WD_PRE_HI:`RSX_WD_PRE_LO] = pre_q[`RSX_BYTE_W-1:0];
        end
        `RSX_ADDR_DIR: begin
          rdata_d[`RSX_BYTE_W-1:0] = dir_a_q;
          rdata_d[2*`RSX_BYTE_W-1:`RSX_BYTE_W] = dir_b_q;
        end
        `RSX_ADDR_WAKE: rdata_d[0] = state_q[1];
        default: rdata_d = {`RSX_DATA_W{1'b0}};
      endcase
    end
  end

  // read data register, loaded in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= {`RSX_DATA_W{1'b0}};
    end else if (rd_strobe) begin
      prdata <= rdata_d;
    end
  end

  // run / halt sequencing
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (halt_exec) begin
          state_d = ST_HALT; // RULE3
        end
      end
      ST_HALT: begin
        if (wr_strobe && wake_hit && pwdata[0]) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RUN;
      halted_q <= 1'b0;
      osc_run_q <= 1'b1;
    end else begin
      state_q <= state_d;
      halted_q <= state_d[1]; // RULE3
      osc_run_q <= state_d[0]; // RULE3
    end
  end

  // watchdog next value, frozen while halted
  always @* begin
    wdog_d = wdog_q;
    pre_d = pre_q;
    if (halt_exec) begin
      wdog_d = {WDOG_W{1'b0}}; // RULE1
      pre_d = {PRE_W{1'b0}}; // RULE1
    end else if (state_q[0]) begin
      pre_d = pre_q + {{(PRE_W-1){1'b0}}, 1'b1};
      if (&pre_q) begin
        wdog_d = wdog_q + {{(WDOG_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // watchdog counter and prescaler
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_q <= {WDOG_W{1'b0}};
      pre_q <= {PRE_W{1'b0}};
    end else begin
      wdog_q <= wdog_d;
      pre_q <= pre_d;
    end
  end

  // accumulator next value, command result before bus write
  always @* begin
    acc_d = acc_q;
    if (to_acc) begin
      acc_d = alu_res; // RULE10
    end else if (wr_strobe && (paddr == `RSX_ADDR_ACC)) begin
      acc_d = pwdata[`RSX_BYTE_W-1:0];
    end
  end

  // accumulator
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= `RSX_BYTE_ZERO;
    end else begin
      acc_q <= acc_d;
    end
  end

  // status next value, command flags before bus write
  always @* begin
    status_d = status_q;
    if (exec) begin
      if (halt_exec) begin
        status_d[`RSX_ST_EXPIRY] = 1'b1; // RULE2
        status_d[`RSX_ST_PWRDN] = 1'b0; // RULE2
      end
      if (alu_wr_carry) begin
        status_d[`RSX_ST_CARRY] = alu_carry;
      end
      if (alu_wr_half) begin
        status_d[`RSX_ST_HALF] = alu_half; // RULE6
      end
      if (alu_wr_zero) begin
        status_d[`RSX_ST_ZERO] = alu_zero; // RULE12
      end
    end else if (wr_strobe && (paddr == `RSX_ADDR_STATUS)) begin
      status_d = pwdata[`RSX_ST_W-1:0];
    end
  end

  // status flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `RSX_ST_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // direction register next values
  always @* begin
    dir_a_d = dir_a_q;
    dir_b_d = dir_b_q;
    if (exec && (cmd_op == `RSX_OP_DIR)) begin
      if (cmd_f == `RSX_DIR_SEL_A) begin
        dir_a_d = acc_q; // RULE8
      end else begin
        dir_b_d = acc_q; // RULE8
      end
    end
  end

  // direction registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_a_q <= `RSX_DIR_RESET;
      dir_b_q <= `RSX_DIR_RESET;
    end else begin
      dir_a_q <= dir_a_d;
      dir_b_q <= dir_b_d;
    end
  end

  // file registers
  genvar gi;
  generate
    for (gi = 0; gi < `RSX_FILE_N; gi = gi + 1) begin : g_file
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          file_q[gi] <= `RSX_BYTE_ZERO;
        end else if (to_file && (cmd_f == gi)) begin
          file_q[gi] <= alu_res; // RULE11
        end else if (wr_strobe && bus_is_file && (bus_idx == gi)) begin
          file_q[gi] <= pwdata[`RSX_BYTE_W-1:0];
        end
      end
    end
  endgenerate

endmodule // rsx_exec

// *** rsx_defines.vh ***
`ifndef RSX_DEFINES_VH
`define RSX_DEFINES_VH

// register byte addresses
`define RSX_ADDR_W 8
`define RSX_ADDR_CMD 8'h00
`define RSX_ADDR_ACC 8'h04
`define RSX_ADDR_STATUS 8'h08
`define RSX_ADDR_WDOG 8'h0c
`define RSX_ADDR_DIR 8'h10
`define RSX_ADDR_WAKE 8'h14
`define RSX_ADDR_FILE_BASE 8'h80
`define RSX_ADDR_FILE_SEL_HI 7
`define RSX_ADDR_FILE_SEL_LO 7
`define RSX_ADDR_IDX_HI 6
`define RSX_ADDR_IDX_LO 2

// command word fields
`define RSX_OP_HI 3
`define RSX_OP_LO 0
`define RSX_F_HI 8
`define RSX_F_LO 4
`define RSX_D_BIT 9
`define RSX_LIT_HI 23
`define RSX_LIT_LO 16

// operation codes
`define RSX_OP_W 4
`define RSX_OP_SLEEP 4'h1
`define RSX_OP_ROT_L 4'h2
`define RSX_OP_ROT_R 4'h3
`define RSX_OP_SUB 4'h4
`define RSX_OP_SWAP 4'h5
`define RSX_OP_DIR 4'h6
`define RSX_OP_XOR_F 4'h7
`define RSX_OP_XOR_L 4'h8

// destination bit values
`define RSX_DEST_ACC 1'b0
`define RSX_DEST_FILE 1'b1

// direction register selectors
`define RSX_DIR_SEL_A 5'h06
`define RSX_DIR_SEL_B 5'h07

// status bit positions
`define RSX_ST_CARRY 0
`define RSX_ST_HALF 1
`define RSX_ST_ZERO 2
`define RSX_ST_PWRDN 3
`define RSX_ST_EXPIRY 4
`define RSX_ST_WAKE 5
`define RSX_ST_W 6

// reset values
`define RSX_ST_RESET 6'h18
`define RSX_DIR_RESET 8'hff
`define RSX_BYTE_ZERO 8'h00
`define RSX_WDOG_CLEAR 8'h00

// watchdog read fields
`define RSX_WD_CNT_HI 7
`define RSX_WD_CNT_LO 0
`define RSX_WD_PRE_HI 15
`define RSX_WD_PRE_LO 8

// misc
`define RSX_DATA_W 32
`define RSX_BYTE_W 8
`define RSX_FILE_N 32
`define RSX_FILE_IDX_W 5
`define RSX_NIB_LO_HI 3
`define RSX_NIB_LO_LO 0
`define RSX_NIB_HI_HI 7
`define RSX_NIB_HI_LO 4
`define RSX_MSB 7
`define RSX_LSB 0

`endif

// *** rsx_alu.v ***
`timescale 1ns/1ps
`include "rsx_defines.vh"

module rsx_alu (
  input wire [`RSX_OP_W-1:0] op,
  input wire [`RSX_BYTE_W-1:0] acc,
  input wire [`RSX_BYTE_W-1:0] fval,
  input wire [`RSX_BYTE_W-1:0] lit,
  input wire carry_in,
  output reg [`RSX_BYTE_W-1:0] res,
  output reg carry_out,
  output reg half_out,
  output wire zero_out,
  output reg wr_carry,
  output reg wr_half,
  output reg wr_zero
);

  wire [`RSX_BYTE_W:0] diff;
  wire [`RSX_NIB_HI_LO:0] ndiff;

  assign diff = {1'b0, fval} - {1'b0, acc};
  assign ndiff = {1'b0, fval[`RSX_NIB_LO_HI:`RSX_NIB_LO_LO]} -
                 {1'b0, acc[`RSX_NIB_LO_HI:`RSX_NIB_LO_LO]};
  assign zero_out = (res == `RSX_BYTE_ZERO); // RULE12

  always @* begin
    res = fval;
    carry_out = carry_in;
    half_out = 1'b0;
    wr_carry = 1'b0;
    wr_half = 1'b0;
    wr_zero = 1'b0;
    case (op)
      `RSX_OP_ROT_L: begin
        res = {fval[`RSX_MSB-1:`RSX_LSB], carry_in}; // RULE4
        carry_out = fval[`RSX_MSB]; // RULE4
        wr_carry = 1'b1;
      end
      `RSX_OP_ROT_R: begin
        res = {carry_in, fval[`RSX_MSB:`RSX_LSB+1]}; // RULE5
        carry_out = fval[`RSX_LSB]; // RULE5
        wr_carry = 1'b1;
      end
      `RSX_OP_SUB: begin
        res = diff[`RSX_BYTE_W-1:0]; // RULE6
        carry_out = ~diff[`RSX_BYTE_W]; // RULE6
        half_out = ~ndiff[`RSX_NIB_HI_LO]; // RULE6
        wr_carry = 1'b1;
        wr_half = 1'b1;
        wr_zero = 1'b1;
      end
      `RSX_OP_SWAP: begin
        res = {fval[`RSX_NIB_LO_HI:`RSX_NIB_LO_LO],
               fval[`RSX_NIB_HI_HI:`RSX_NIB_HI_LO]}; // RULE7
      end
      `RSX_OP_XOR_F: begin
        res = acc ^ fval; // RULE9
        wr_zero = 1'b1;
      end
      `RSX_OP_XOR_L: begin
        res = acc ^ lit; // RULE10
        wr_zero = 1'b1;
      end
      default: begin
        res = fval;
      end
    endcase
  end

endmodule // rsx_alu

// *** rsx_exec_monitor.sv ***
`timescale 1ns/1ps
`include "rsx_defines.vh"

module rsx_exec_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire halted_q,
  input wire osc_run_q,
  input wire [7:0] dir_a_q,
  input wire [7:0] dir_b_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire done = psel && penable && pready;
  wire cmd = done && pwrite && paddr == `RSX_ADDR_CMD;
  wire wake = done && pwrite && paddr == `RSX_ADDR_WAKE && pwdata[0];
  wire [3:0] op = pwdata[3:0];
  wire [4:0] fs = pwdata[8:4];
  wire dir_op = cmd && op == `RSX_OP_DIR;

  a_ready_one_wait: assert property ($rose(penable) |-> !pready ##1 pready)
    else $error("ready not after one wait");
  a_halt_enter: assert property (
    cmd && op == `RSX_OP_SLEEP && !pslverr |-> ##[1:2] halted_q && !osc_run_q)
    else $error("halt not entered");
  a_osc_inverse: assert property (osc_run_q == !halted_q)
    else $error("oscillator state wrong");
  a_halt_leave_cause: assert property (
    $fell(halted_q) |-> $past(wake) || $past(wake, 2))
    else $error("halt left without wake");
  a_halted_cmd_refused: assert property (cmd && halted_q |-> pslverr)
    else $error("command taken while halted");
  a_dir_a_src: assert property (
    $changed(dir_a_q) |-> $past(dir_op && fs == 5'h06 && !pslverr))
    else $error("dir a changed wrongly");
  a_dir_b_src: assert property (
    $changed(dir_b_q) |-> $past(dir_op && fs == 5'h07 && !pslverr))
    else $error("dir b changed wrongly");
  a_dir_bad_sel: assert property (
    dir_op && fs != 5'h06 && fs != 5'h07 |-> pslverr)
    else $error("bad direction selector taken");
  a_bad_op_refused: assert property (cmd && (op == 4'h0 || op > 4'h8) |-> pslverr)
    else $error("illegal opcode taken");
endmodule // rsx_exec_monitor

// *** rsx_apb_host.sv ***
`timescale 1ns/1ps

module rsx_apb_host (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule // rsx_apb_host

// *** rsx_exec_tb.sv ***
`timescale 1ns/1ps

module rsx_exec_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, halted_q, osc_run_q, e;
  logic [7:0] paddr, dir_a_q, dir_b_q;
  logic [31:0] pwdata, prdata, r, w0;
  int n_errors = 0;
  int checks = 0;

  always #5 pclk = ~pclk;

  rsx_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halted_q(halted_q), .osc_run_q(osc_run_q), .dir_a_q(dir_a_q),
    .dir_b_q(dir_b_q));
  rsx_apb_host u_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, r, e);
  endtask
  task rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task run(input logic [3:0] op, input logic [4:0] f, input logic d,
    input logic [7:0] k, a, v, s, ea, ev, es);
    wr(8'h04, {24'h0, a});
    wr({1'b1, f, 2'b00}, {24'h0, v});
    wr(8'h08, {24'h0, s});
    wr(8'h00, {8'h0, k, 6'h0, d, f, op});
    chk({31'h0, e}, 32'h0);
    rd(8'h04);
    chk(r, {24'h0, ea});
    rd({1'b1, f, 2'b00});
    chk(r, {24'h0, ev});
    rd(8'h08);
    chk(r, {24'h0, es});
  endtask
  task end_sim;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    end_sim;
  end

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h08);
    chk(r, 32'h18);
    rd(8'h10);
    chk(r, 32'hffff);
    run(4'h2, 5'd3, 1'b1, 8'h00, 8'h55, 8'h81, 8'h19, 8'h55, 8'h03, 8'h19);
    run(4'h2, 5'd3, 1'b0, 8'h00, 8'h00, 8'h40, 8'h1c, 8'h80, 8'h40, 8'h1c);
    run(4'h3, 5'd31, 1'b1, 8'h00, 8'h77, 8'h01, 8'h18, 8'h77, 8'h00, 8'h19);
    run(4'h3, 5'd2, 1'b0, 8'h00, 8'h00, 8'h02, 8'h19, 8'h81, 8'h02, 8'h18);
    run(4'h4, 5'd0, 1'b1, 8'h00, 8'h01, 8'h10, 8'h18, 8'h01, 8'h0f, 8'h19);
    run(4'h4, 5'd1, 1'b0, 8'h00, 8'h05, 8'h05, 8'h18, 8'h00, 8'h05, 8'h1f);
    run(4'h4, 5'd4, 1'b1, 8'h00, 8'h04, 8'h03, 8'h1f, 8'h04, 8'hff, 8'h18);
    run(4'h5, 5'd5, 1'b0, 8'h00, 8'h00, 8'ha5, 8'h1f, 8'h5a, 8'ha5, 8'h1f);
    run(4'h5, 5'd6, 1'b1, 8'h00, 8'h11, 8'h3c, 8'h18, 8'h11, 8'hc3, 8'h18);
    run(4'h7, 5'd7, 1'b1, 8'h00, 8'h0f, 8'hf0, 8'h1f, 8'h0f, 8'hff, 8'h1b);
    run(4'h7, 5'd8, 1'b0, 8'h00, 8'h33, 8'h33, 8'h18, 8'h00, 8'h33, 8'h1c);
    run(4'h8, 5'd9, 1'b1, 8'hff, 8'h0f, 8'h22, 8'h1c, 8'hf0, 8'h22, 8'h18);
    run(4'h8, 5'd9, 1'b0, 8'h00, 8'h00, 8'h22, 8'h18, 8'h00, 8'h22, 8'h1c);
    run(4'h6, 5'd6, 1'b0, 8'h00, 8'h5a, 8'h00, 8'h1f, 8'h5a, 8'h00, 8'h1f);
    run(4'h6, 5'd7, 1'b0, 8'h00, 8'ha5, 8'h00, 8'h18, 8'ha5, 8'h00, 8'h18);
    rd(8'h10);
    chk(r, 32'ha55a);
    chk({16'h0, dir_b_q, dir_a_q}, 32'ha55a);
    wr(8'h00, 32'h56);
    chk({31'h0, e}, 32'h1);
    wr(8'h00, 32'h9);
    chk({31'h0, e}, 32'h1);
    rd(8'h40);
    chk({31'h0, e}, 32'h1);
    rd(8'h0c);
    chk({31'h0, r[15:0] != 16'h0}, 32'h1);
    wr(8'h08, 32'h2f);
    wr(8'h00, 32'h1);
    rd(8'h08);
    chk(r, 32'h37);
    rd(8'h0c);
    w0 = r;
    chk({24'h0, r[7:0]}, 32'h0);
    chk({24'h0, r[15:8]}, 32'h0);
    rd(8'h0c);
    chk(r, w0);
    chk({30'h0, halted_q, osc_run_q}, 32'h2);
    rd(8'h14);
    chk(r, 32'h1);
    wr(8'h00, 32'h2);
    chk({31'h0, e}, 32'h1);
    wr(8'h14, 32'h1);
    rd(8'h14);
    chk(r, 32'h0);
    chk({30'h0, halted_q, osc_run_q}, 32'h1);
    end_sim;
  end
endmodule // rsx_exec_tb

bind rsx_exec rsx_exec_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .halted_q(halted_q), .osc_run_q(osc_run_q),
  .dir_a_q(dir_a_q), .dir_b_q(dir_b_q));
